// [verilog/humid_temp_map.svh]
`ifndef HUMID_TEMP_MAP_SVH
`define HUMID_TEMP_MAP_SVH

// Bus identity and command bytes.
`define SENSOR_ADDR 7'h54
`define CMD_TEMP_NOHOLD 8'hf3
`define CMD_COMBO_NOHOLD 8'hf5
`define CMD_STOP_PERIODIC 8'h30

// Result checksum.
`define CRC_POLY 8'h1d
`define CRC_INIT 8'hff
`define CRC_XOR_OUT 8'h00

// Alert status byte layout; bits not listed read as zero.
`define STAT_HUMID_UNDER_BIT 0
`define STAT_HUMID_OVER_BIT 1
`define STAT_TEMP_UNDER_BIT 2
`define STAT_TEMP_OVER_BIT 3
`define STAT_RESET 8'h00

// System clock rate.
`define CLK_SYS_KHZ 10000

// Longest conversion times in microseconds, by resolution code 0..3.
`define CONV_TEMP_8_US 370
`define CONV_TEMP_10_US 450
`define CONV_TEMP_12_US 600
`define CONV_TEMP_14_US 910
`define CONV_COMBO_8_US 640
`define CONV_COMBO_10_US 800
`define CONV_COMBO_12_US 1040
`define CONV_COMBO_14_US 1700

// Periodic measurement intervals in milliseconds, by interval code 0..2.
`define PERIOD_0_MS 500
`define PERIOD_1_MS 1000
`define PERIOD_2_MS 2500

`endif

// [verilog/humid_temp_pkg.sv]
package humid_temp_pkg;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_ADDR_ACK = 7'b0000100,
		ST_WR_BYTE = 7'b0001000,
		ST_WR_ACK = 7'b0010000,
		ST_RD_BYTE = 7'b0100000,
		ST_RD_ACK = 7'b1000000
	} link_state_type;

	typedef logic [13:0] sample_type;

endpackage : humid_temp_pkg

// [verilog/byte_stream_if.sv]
`timescale 1ns/1ns

interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// [verilog/byte_skid_fifo.sv]
`timescale 1ns/1ns

module byte_skid_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic flush,
	byte_stream_if.snk fill,
	byte_stream_if.src drain
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("byte_skid_fifo needs a power-of-two DEPTH of at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign fill.ready = (cnt_r != FULL_CNT);
	assign drain.valid = (cnt_r != '0);
	assign drain.data = mem_r[rd_r];
	assign push = fill.valid && fill.ready;
	assign pop = drain.ready && drain.valid;

	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (flush) begin
			wr_nxt = '0;
			rd_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push) begin
				mem_nxt[wr_r] = fill.data;
				wr_nxt = wr_r + PW'(1);
			end
			if (pop) begin
				rd_nxt = rd_r + PW'(1);
			end
			if (push && !pop) begin
				cnt_nxt = cnt_r + (PW + 1)'(1);
			end else if (pop && !push) begin
				cnt_nxt = cnt_r - (PW + 1)'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (ce) begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			mem_r <= mem_nxt;
		end
	end

endmodule : byte_skid_fifo

// [verilog/humidity_temp_result_readout.sv]
// What this block does
// - Ready result: acknowledge read address, send bytes.
// - Conversion running outside periodic mode: NACK read address, no data.
// - Two bytes temperature, four combined, humidity first.
// - Values go out most significant bit first.
// - Results always scaled to fourteen bits.
// - Temperature conversion times per resolution.
// - Combined conversion times per resolution.
// - Checksum byte follows over four data bytes.
// - Temperature-only checksum uses zero humidity bytes.
// - Checksum polynomial 1d, init ff, unreflected.
// - Periodic fetch returns latest stored result.
// - Periodic mode ignores all but fetch, stop.
// - Stop command 30 ends periodic mode.
// - Alert high at reset; periodic shows activity.
// - Outside periodic mode alert stays high.
// - Activity alert only with thresholds disabled.
// - Threshold alerts: limit, polarity, hysteresis.
// - Enabled alerts prepend status byte on fetch.
// - Status byte carries four limit flags.
// - Commands f3 and f5 start no-hold conversions.
// - Answer only the fixed address 54.
// - Resolution codes select 8 to 14 bits.
// - Periodic enable bit starts periodic measurement.
`timescale 1ns/1ns
`include "humid_temp_map.svh"

module humidity_temp_result_readout #(
	parameter int CNT_W = 25,
	parameter int TEMP_CONV_CYCLES [4] = '{
		`CONV_TEMP_8_US * `CLK_SYS_KHZ / 1000, `CONV_TEMP_10_US * `CLK_SYS_KHZ / 1000,
		`CONV_TEMP_12_US * `CLK_SYS_KHZ / 1000, `CONV_TEMP_14_US * `CLK_SYS_KHZ / 1000},
	parameter int COMBO_CONV_CYCLES [4] = '{
		`CONV_COMBO_8_US * `CLK_SYS_KHZ / 1000, `CONV_COMBO_10_US * `CLK_SYS_KHZ / 1000,
		`CONV_COMBO_12_US * `CLK_SYS_KHZ / 1000, `CONV_COMBO_14_US * `CLK_SYS_KHZ / 1000},
	parameter int PERIOD_CYCLES [3] = '{
		`PERIOD_0_MS * `CLK_SYS_KHZ, `PERIOD_1_MS * `CLK_SYS_KHZ, `PERIOD_2_MS * `CLK_SYS_KHZ}
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] temp_res,
	input wire logic [1:0] humid_res,
	input wire logic periodic_cfg_en,
	input wire logic [1:0] period_sel,
	input wire logic alert_polarity,
	input wire logic [3:0] alert_en,
	input wire logic [3:0][13:0] alert_thresh,
	input wire logic [13:0] alert_hyst,
	input wire logic [13:0] humid_raw,
	input wire logic [13:0] temp_raw,
	output logic alert,
	output logic periodic_active,
	output logic conv_busy
);

	typedef logic [CNT_W-1:0] cnt_type;

	if (CNT_W < 2 || CNT_W > 31 || PERIOD_CYCLES[2] >= (1 << CNT_W) || PERIOD_CYCLES[0] < 1
			|| TEMP_CONV_CYCLES[0] < 1 || COMBO_CONV_CYCLES[3] >= (1 << CNT_W)) begin : g_bad
		$error("humidity_temp_result_readout: counts do not fit CNT_W or are zero");
	end

	function automatic humid_temp_pkg::sample_type scale14(input logic [13:0] raw, input logic [1:0] code);
		unique case (code)
			2'h0: return {raw[7:0], 6'h00};
			2'h1: return {raw[9:0], 4'h0};
			2'h2: return {raw[11:0], 2'h0};
			2'h3: return raw;
		endcase
	endfunction : scale14

	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = `CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
		end
		return c ^ `CRC_XOR_OUT;
	endfunction : crc8

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; index 0 is the first flop, 2 holds the previous sample.

	logic [2:0] scl_r, scl_nxt, sda_r, sda_nxt;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_comb begin
		scl_nxt = {scl_r[1:0], scl_in};
		sda_nxt = {sda_r[1:0], sda_in};
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_r <= 3'h7;
			sda_r <= 3'h7;
		end else if (ce) begin
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
		end
	end

	assign scl_rise = scl_r[1] && !scl_r[2];
	assign scl_fall = !scl_r[1] && scl_r[2];
	assign start_det = scl_r[1] && scl_r[2] && !sda_r[1] && sda_r[2];
	assign stop_det = scl_r[1] && scl_r[2] && sda_r[1] && !sda_r[2];

	////////////////////////////////////////////////////////////////////////////////
	// Serial link state machine.

	byte_stream_if #(.W(8)) up_s ();
	byte_stream_if #(.W(8)) dn_s ();

	humid_temp_pkg::link_state_type state_r, state_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] shift_r, shift_nxt, tx_byte;
	logic sda_drv_r, sda_drv_nxt, rd_dir_r, rd_dir_nxt, mack_r, mack_nxt, first_r, first_nxt;
	logic cmd_pulse, seq_start, pop, flush, read_ok;

	// An empty buffer can only mean the master clocked past the end; it then reads ones.
	assign tx_byte = dn_s.valid ? dn_s.data : 8'hff;
	assign dn_s.ready = pop;

	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		sda_drv_nxt = sda_drv_r;
		rd_dir_nxt = rd_dir_r;
		mack_nxt = mack_r;
		first_nxt = first_r;
		cmd_pulse = 1'b0;
		seq_start = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		if (start_det) begin
			state_nxt = humid_temp_pkg::ST_ADDR;
			bit_cnt_nxt = 4'h0;
			sda_drv_nxt = 1'b0;
			first_nxt = 1'b1;
			flush = 1'b1;
		end else if (stop_det) begin
			state_nxt = humid_temp_pkg::ST_IDLE;
			sda_drv_nxt = 1'b0;
			flush = 1'b1;
		end else begin
			unique case (state_r)
				humid_temp_pkg::ST_IDLE: begin
				end
				humid_temp_pkg::ST_ADDR, humid_temp_pkg::ST_WR_BYTE: begin
					if (scl_rise && bit_cnt_r != 4'h8) begin
						shift_nxt = {shift_r[6:0], sda_r[1]};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						if (state_r == humid_temp_pkg::ST_WR_BYTE) begin
							sda_drv_nxt = 1'b1;
							cmd_pulse = first_r;
							state_nxt = humid_temp_pkg::ST_WR_ACK;
						end else if (shift_r[7:1] != `SENSOR_ADDR) begin
							state_nxt = humid_temp_pkg::ST_IDLE;
						end else if (!shift_r[0]) begin
							sda_drv_nxt = 1'b1;
							rd_dir_nxt = 1'b0;
							state_nxt = humid_temp_pkg::ST_ADDR_ACK;
						end else if (read_ok) begin
							sda_drv_nxt = 1'b1;
							rd_dir_nxt = 1'b1;
							seq_start = 1'b1;
							state_nxt = humid_temp_pkg::ST_ADDR_ACK;
						end else begin
							state_nxt = humid_temp_pkg::ST_IDLE;
						end
					end
				end
				humid_temp_pkg::ST_ADDR_ACK, humid_temp_pkg::ST_RD_ACK: begin
					if (scl_rise && state_r == humid_temp_pkg::ST_RD_ACK) begin
						mack_nxt = !sda_r[1];
					end else if (scl_fall) begin
						if (state_r == humid_temp_pkg::ST_ADDR_ACK && !rd_dir_r) begin
							sda_drv_nxt = 1'b0;
							bit_cnt_nxt = 4'h0;
							state_nxt = humid_temp_pkg::ST_WR_BYTE;
						end else if (state_r == humid_temp_pkg::ST_ADDR_ACK || mack_r) begin
							pop = dn_s.valid;
							sda_drv_nxt = !tx_byte[7];
							shift_nxt = {tx_byte[6:0], 1'b0};
							bit_cnt_nxt = 4'h1;
							state_nxt = humid_temp_pkg::ST_RD_BYTE;
						end else begin
							sda_drv_nxt = 1'b0;
							state_nxt = humid_temp_pkg::ST_IDLE;
						end
					end
				end
				humid_temp_pkg::ST_RD_BYTE: begin
					if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_drv_nxt = 1'b0;
							state_nxt = humid_temp_pkg::ST_RD_ACK;
						end else begin
							sda_drv_nxt = !shift_r[7];
							shift_nxt = {shift_r[6:0], 1'b0};
							bit_cnt_nxt = bit_cnt_r + 4'h1;
						end
					end
				end
				humid_temp_pkg::ST_WR_ACK: begin
					if (scl_fall) begin
						sda_drv_nxt = 1'b0;
						bit_cnt_nxt = 4'h0;
						first_nxt = 1'b0;
						state_nxt = humid_temp_pkg::ST_WR_BYTE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= humid_temp_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			sda_drv_r <= 1'b0;
			rd_dir_r <= 1'b0;
			mack_r <= 1'b0;
			first_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			sda_drv_r <= sda_drv_nxt;
			rd_dir_r <= rd_dir_nxt;
			mack_r <= mack_nxt;
			first_r <= first_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_drv_r;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion timing, periodic mode and the result holding registers.

	logic periodic_r, periodic_nxt, cfg_prev_r, busy_r, busy_nxt, combo_r, combo_nxt;
	cnt_type conv_cnt_r, conv_cnt_nxt, period_cnt_r, period_cnt_nxt;
	humid_temp_pkg::sample_type res_h_r, res_h_nxt, res_t_r, res_t_nxt, new_h, new_t;
	logic [7:0] res_crc_r, res_crc_nxt;
	logic res_combo_r, res_combo_nxt, res_valid_r, res_valid_nxt, conv_done, start_conv, start_combo;
	logic [1:0] max_res;

	assign max_res = (humid_res > temp_res) ? humid_res : temp_res;
	assign new_h = combo_r ? scale14(humid_raw, humid_res) : 14'h0000;
	assign new_t = scale14(temp_raw, temp_res);

	always_comb begin
		periodic_nxt = periodic_r;
		busy_nxt = busy_r;
		combo_nxt = combo_r;
		conv_cnt_nxt = conv_cnt_r;
		period_cnt_nxt = period_cnt_r;
		res_h_nxt = res_h_r;
		res_t_nxt = res_t_r;
		res_crc_nxt = res_crc_r;
		res_combo_nxt = res_combo_r;
		res_valid_nxt = res_valid_r;
		conv_done = 1'b0;
		start_conv = 1'b0;
		start_combo = 1'b0;
		if (periodic_cfg_en && !cfg_prev_r && !periodic_r) begin
			periodic_nxt = 1'b1;
			start_conv = 1'b1;
			start_combo = 1'b1;
			period_cnt_nxt = cnt_type'(PERIOD_CYCLES[(period_sel == 2'h3) ? 2'h2 : period_sel] - 1);
		end else if (periodic_r) begin
			if (cmd_pulse && shift_r == `CMD_STOP_PERIODIC) begin
				periodic_nxt = 1'b0;
			end else if (period_cnt_r == '0) begin
				start_conv = 1'b1;
				start_combo = 1'b1;
				period_cnt_nxt = cnt_type'(PERIOD_CYCLES[(period_sel == 2'h3) ? 2'h2 : period_sel] - 1);
			end else begin
				period_cnt_nxt = period_cnt_r - cnt_type'(1);
			end
		end else if (cmd_pulse && (shift_r == `CMD_TEMP_NOHOLD || shift_r == `CMD_COMBO_NOHOLD)) begin
			start_conv = 1'b1;
			start_combo = (shift_r == `CMD_COMBO_NOHOLD);
		end
		if (start_conv) begin
			busy_nxt = 1'b1;
			combo_nxt = start_combo;
			conv_cnt_nxt = start_combo ? cnt_type'(COMBO_CONV_CYCLES[max_res] - 1)
				: cnt_type'(TEMP_CONV_CYCLES[temp_res] - 1);
		end else if (busy_r) begin
			if (conv_cnt_r == '0) begin
				busy_nxt = 1'b0;
				conv_done = 1'b1;
				res_h_nxt = new_h;
				res_t_nxt = new_t;
				res_crc_nxt = crc8({2'b00, new_h, 2'b00, new_t});
				res_combo_nxt = combo_r;
				res_valid_nxt = 1'b1;
			end else begin
				conv_cnt_nxt = conv_cnt_r - cnt_type'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			periodic_r <= 1'b0;
			cfg_prev_r <= 1'b0;
			busy_r <= 1'b0;
			combo_r <= 1'b0;
			conv_cnt_r <= '0;
			period_cnt_r <= '0;
			res_h_r <= 14'h0000;
			res_t_r <= 14'h0000;
			res_crc_r <= 8'h00;
			res_combo_r <= 1'b0;
			res_valid_r <= 1'b0;
		end else if (ce) begin
			periodic_r <= periodic_nxt;
			cfg_prev_r <= periodic_cfg_en;
			busy_r <= busy_nxt;
			combo_r <= combo_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			period_cnt_r <= period_cnt_nxt;
			res_h_r <= res_h_nxt;
			res_t_r <= res_t_nxt;
			res_crc_r <= res_crc_nxt;
			res_combo_r <= res_combo_nxt;
			res_valid_r <= res_valid_nxt;
		end
	end

	// In periodic mode a fetch may overlap a conversion and gets the held result.
	assign read_ok = res_valid_r && (periodic_r || !busy_r);
	assign periodic_active = periodic_r;
	assign conv_busy = busy_r;

	////////////////////////////////////////////////////////////////////////////////
	// Threshold flags with hysteresis; channel 0/1 humidity low/high, 2/3 temperature.

	logic [3:0] flag_r, flag_nxt, trig;
	logic temp_over_limit_flag, temp_under_limit_flag, humid_over_limit_flag, humid_under_limit_flag;

	for (genvar g = 0; g < 4; g++) begin : g_flag
		logic [14:0] val, lim;
		assign val = {1'b0, (g < 2) ? new_h : new_t};
		assign lim = {1'b0, alert_thresh[g]};
		always_comb begin
			flag_nxt[g] = flag_r[g];
			if (conv_done && periodic_r && (combo_r || g >= 2)) begin
				if (g % 2 == 1) begin
					if (val > lim) begin
						flag_nxt[g] = 1'b1;
					end else if (val + {1'b0, alert_hyst} < lim) begin
						flag_nxt[g] = 1'b0;
					end
				end else begin
					if (val < lim) begin
						flag_nxt[g] = 1'b1;
					end else if (val > lim + {1'b0, alert_hyst}) begin
						flag_nxt[g] = 1'b0;
					end
				end
			end
		end
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				flag_r[g] <= 1'b0;
			end else if (ce) begin
				flag_r[g] <= flag_nxt[g];
			end
		end
		assign trig[g] = flag_r[g] && alert_en[g];
	end

	assign humid_under_limit_flag = trig[0];
	assign humid_over_limit_flag = trig[1];
	assign temp_under_limit_flag = trig[2];
	assign temp_over_limit_flag = trig[3];

	////////////////////////////////////////////////////////////////////////////////
	// Alert pin.

	logic alert_r, alert_nxt;

	always_comb begin
		if (!periodic_r) begin
			alert_nxt = 1'b1;
		end else if (alert_en == 4'h0) begin
			alert_nxt = busy_r;
		end else begin
			alert_nxt = (|trig) ^ alert_polarity;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alert_r <= 1'b1;
		end else if (ce) begin
			alert_r <= alert_nxt;
		end
	end

	assign alert = alert_r;

	////////////////////////////////////////////////////////////////////////////////
	// Byte sequencer: snapshot at address time, then feed the buffer in order.

	logic [2:0] idx_r, idx_nxt;
	logic run_r, run_nxt, tx_combo_r, tx_combo_nxt, tx_stat_en_r, tx_stat_en_nxt, inc;
	humid_temp_pkg::sample_type tx_h_r, tx_h_nxt, tx_t_r, tx_t_nxt;
	logic [7:0] tx_crc_r, tx_crc_nxt, tx_stat_r, tx_stat_nxt, stat_byte;

	always_comb begin
		stat_byte = `STAT_RESET;
		stat_byte[`STAT_TEMP_OVER_BIT] = temp_over_limit_flag;
		stat_byte[`STAT_TEMP_UNDER_BIT] = temp_under_limit_flag;
		stat_byte[`STAT_HUMID_OVER_BIT] = humid_over_limit_flag;
		stat_byte[`STAT_HUMID_UNDER_BIT] = humid_under_limit_flag;
	end

	always_comb begin
		unique case (idx_r)
			3'h0: inc = tx_stat_en_r;
			3'h1, 3'h2: inc = tx_combo_r;
			default: inc = 1'b1;
		endcase
		unique case (idx_r)
			3'h0: up_s.data = tx_stat_r;
			3'h1: up_s.data = {2'b00, tx_h_r[13:8]};
			3'h2: up_s.data = tx_h_r[7:0];
			3'h3: up_s.data = {2'b00, tx_t_r[13:8]};
			3'h4: up_s.data = tx_t_r[7:0];
			default: up_s.data = tx_crc_r;
		endcase
		up_s.valid = run_r && inc;
		idx_nxt = idx_r;
		run_nxt = run_r;
		tx_h_nxt = tx_h_r;
		tx_t_nxt = tx_t_r;
		tx_crc_nxt = tx_crc_r;
		tx_stat_nxt = tx_stat_r;
		tx_combo_nxt = tx_combo_r;
		tx_stat_en_nxt = tx_stat_en_r;
		if (flush) begin
			run_nxt = 1'b0;
		end else if (seq_start) begin
			run_nxt = 1'b1;
			idx_nxt = 3'h0;
			tx_h_nxt = res_h_r;
			tx_t_nxt = res_t_r;
			tx_crc_nxt = res_crc_r;
			tx_combo_nxt = res_combo_r;
			tx_stat_nxt = stat_byte;
			tx_stat_en_nxt = periodic_r && (alert_en != 4'h0);
		end else if (run_r && (!inc || up_s.ready)) begin
			idx_nxt = idx_r + 3'h1;
			run_nxt = (idx_r != 3'h5);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			idx_r <= 3'h0;
			run_r <= 1'b0;
			tx_h_r <= 14'h0000;
			tx_t_r <= 14'h0000;
			tx_crc_r <= 8'h00;
			tx_stat_r <= `STAT_RESET;
			tx_combo_r <= 1'b0;
			tx_stat_en_r <= 1'b0;
		end else if (ce) begin
			idx_r <= idx_nxt;
			run_r <= run_nxt;
			tx_h_r <= tx_h_nxt;
			tx_t_r <= tx_t_nxt;
			tx_crc_r <= tx_crc_nxt;
			tx_stat_r <= tx_stat_nxt;
			tx_combo_r <= tx_combo_nxt;
			tx_stat_en_r <= tx_stat_en_nxt;
		end
	end

	byte_skid_fifo #(.WIDTH(8), .DEPTH(2)) u_tx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.flush(flush),
		.fill(up_s),
		.drain(dn_s)
	);

endmodule : humidity_temp_result_readout

// [verif/readout_assertions.sv]
`timescale 1ns/1ns
module readout_assertions #(
	parameter int COMBO_CONV_CYCLES [4] = '{300, 350, 400, 500}
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [1:0] temp_res,
	input wire logic [1:0] humid_res,
	input wire logic periodic_cfg_en,
	input wire logic [1:0] period_sel,
	input wire logic alert_polarity,
	input wire logic [3:0] alert_en,
	input wire logic [3:0][13:0] alert_thresh,
	input wire logic [13:0] alert_hyst,
	input wire logic [13:0] humid_raw,
	input wire logic [13:0] temp_raw,
	input wire logic alert,
	input wire logic periodic_active,
	input wire logic conv_busy
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [15:0] busy_cnt_r;
	logic [15:0] busy_cnt_nxt;
	int conv_c;
	////////////////////////////////////////////////////////////////
	// Frozen cycles do not count, so a ce gap cannot look like a slow conversion.
	always_comb begin
		busy_cnt_nxt = busy_cnt_r;
		if (ce)
			busy_cnt_nxt = conv_busy ? busy_cnt_r + 16'h1 : 16'h0;
		conv_c = COMBO_CONV_CYCLES[(temp_res > humid_res) ? temp_res : humid_res];
	end
	always_ff @(posedge clk_sys) begin
		busy_cnt_r <= rst ? 16'h0 : busy_cnt_nxt;
	end
	////////////////////////////////////////////////////////////////
	sequence s_meas_begin;
		periodic_active && alert_en == 4'h0 && $rose(conv_busy);
	endsequence
	sequence s_meas_end;
		periodic_active && alert_en == 4'h0 && $fell(conv_busy);
	endsequence
	a_meas_alert_high: assert property (s_meas_begin |-> ##[0:1] alert)
		else $error("alert not high during measurement");
	a_meas_alert_low: assert property (s_meas_end |-> ##[0:1] !alert)
		else $error("alert not low between measurements");
	a_alert_idle_high: assert property (!periodic_active && !$past(periodic_active)
		&& !$past(periodic_active, 2) |-> alert) else $error("alert low outside periodic mode");
	a_reset_outputs: assert property ($fell(rst) |-> alert && !periodic_active
		&& !conv_busy && !sda_oe) else $error("wrong output values after reset");
	a_busy_bounded: assert property (busy_cnt_r <= 2 * COMBO_CONV_CYCLES[3] + 2)
		else $error("conversion runs too long");
	a_periodic_conv_time: assert property ($fell(conv_busy) && periodic_active
		|-> busy_cnt_r + 1 >= conv_c && busy_cnt_r <= conv_c + 1) else $error("periodic conversion time wrong");
	a_periodic_starts: assert property ($rose(periodic_cfg_en) && !periodic_active
		|-> ##[1:3] periodic_active) else $error("periodic mode not entered");
	a_periodic_first_meas: assert property ($rose(periodic_active) |-> ##[0:3] conv_busy)
		else $error("periodic mode started no measurement");
	a_ce_freezes: assert property (!ce |=> $stable(alert) && $stable(conv_busy) && $stable(sda_oe))
		else $error("outputs moved while clock enable low");
endmodule : readout_assertions

bind humidity_temp_result_readout readout_assertions #(.COMBO_CONV_CYCLES(COMBO_CONV_CYCLES)) readout_assertions_i (
	.clk_sys, .rst, .ce, .scl_in, .sda_in, .sda_out, .sda_oe, .temp_res, .humid_res, .periodic_cfg_en,
	.period_sel, .alert_polarity, .alert_en, .alert_thresh, .alert_hyst, .humid_raw, .temp_raw, .alert,
	.periodic_active, .conv_busy);

// [verif/i2c_master_model.sv]
`timescale 1ns/1ns
module i2c_master_model (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// SCL stands high between frames; the odd offset drifts the link phase against clk_sys.
	task automatic start();
		#13;
		sda_drv = 1'b1;
		scl = 1'b1;
		#400;
		sda_drv = 1'b0;
		#400;
		scl = 1'b0;
	endtask : start
	task automatic stop();
		#100;
		sda_drv = 1'b0;
		#300;
		scl = 1'b1;
		#400;
		sda_drv = 1'b1;
		#400;
	endtask : stop
	task automatic xbit(input logic b, output logic r);
		#100;
		sda_drv = b;
		#300;
		scl = 1'b1;
		#200;
		r = sda_line;
		#200;
		scl = 1'b0;
	endtask : xbit
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r);
		xbit(1'b1, r);
		ack = ~r;
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, r);
			d[i] = r;
		end
		xbit(last, r);
	endtask : rbyte
endmodule : i2c_master_model

// [verif/tb.sv]
`timescale 1ns/1ns
`include "humid_temp_map.svh"
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [1:0] temp_res = 2'h0, humid_res = 2'h0, period_sel = 2'h0;
	logic periodic_cfg_en = 1'b0, alert_polarity = 1'b0;
	logic [3:0] alert_en = 4'h0;
	logic [3:0][13:0] alert_thresh = '0;
	logic [13:0] alert_hyst = 14'h0, humid_raw = 14'h0, temp_raw = 14'h0;
	logic sda_out, sda_oe, alert, periodic_active, conv_busy, scl, sda_m;
	wire sda = sda_m & (sda_out | ~sda_oe);
	int err_total = 0, total_checks = 0;
	logic [7:0] q [$];
	logic [7:0] e [$];
	always #50 clk_sys = ~clk_sys;
	humidity_temp_result_readout #(.TEMP_CONV_CYCLES('{200, 250, 300, 400}),
		.COMBO_CONV_CYCLES('{300, 350, 400, 500}), .PERIOD_CYCLES('{1500, 2000, 2500})
	) humidity_temp_result_readout_i (.clk_sys, .rst, .ce, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.temp_res, .humid_res, .periodic_cfg_en, .period_sel, .alert_polarity, .alert_en, .alert_thresh,
		.alert_hyst, .humid_raw, .temp_raw, .alert, .periodic_active, .conv_busy);
	i2c_master_model i2c_master_model_i (.scl(scl), .sda_drv(sda_m), .sda_line(sda));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
		return c;
	endfunction : crc8
	function automatic logic [13:0] raw(input logic [1:0] c);
		return 14'($urandom) & ~(14'h3fff << (8 + 2 * c));
	endfunction : raw
	function automatic logic [13:0] scale(input logic [1:0] c, input logic [13:0] v);
		return v << (6 - 2 * c);
	endfunction : scale
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] c);
		logic a;
		i2c_master_model_i.start();
		i2c_master_model_i.wbyte({`SENSOR_ADDR, 1'b0}, a);
		chk(8'(a), 8'h1);
		i2c_master_model_i.wbyte(c, a);
		i2c_master_model_i.stop();
	endtask : cmd
	task automatic rd(input int n, output logic a);
		logic [7:0] b;
		i2c_master_model_i.start();
		i2c_master_model_i.wbyte({`SENSOR_ADDR, 1'b1}, a);
		q.delete();
		for (int i = 0; a === 1'b1 && i < n; i++) begin
			i2c_master_model_i.rbyte(i == n - 1, b);
			q.push_back(b);
		end
		i2c_master_model_i.stop();
	endtask : rd
	task automatic build(input logic [13:0] h, input logic [13:0] t, input logic comb, input logic [8:0] sb);
		e.delete();
		if (sb[8])
			e.push_back(sb[7:0]);
		if (comb) begin
			e.push_back({2'h0, h[13:8]});
			e.push_back(h[7:0]);
		end
		e.push_back({2'h0, t[13:8]});
		e.push_back(t[7:0]);
		e.push_back(crc8({2'h0, comb ? h : 14'h0, 2'h0, t}));
	endtask : build
	task automatic cmpq();
		chk(8'(q.size()), 8'(e.size()));
		foreach (e[i])
			chk(q[i], e[i]);
	endtask : cmpq
	task automatic wconv();
		int n;
		n = 0;
		while (conv_busy !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		while (conv_busy !== 1'b0 && n < 8000) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : wconv
	task automatic complete_run();
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////
	initial begin
		#8000000;
		err_total++;
		complete_run();
	end
	initial begin
		logic a;
		logic pol;
		logic [3:0] en;
		logic [13:0] h, t;
		logic [1:0] tr, hr;
		int n;
		void'($urandom(32'h878d));
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(8'(alert), 8'h1);
		rd(3, a);
		chk(8'(a), 8'h0);
		i2c_master_model_i.start();
		i2c_master_model_i.wbyte({`SENSOR_ADDR ^ 7'(1 + $urandom % 127), 1'b0}, a);
		i2c_master_model_i.stop();
		chk(8'(a), 8'h0);
		for (int k = 0; k < 8; k++) begin
			tr = 2'(k / 2);
			hr = 2'($urandom);
			h = raw(hr);
			t = raw(tr);
			@(posedge clk_sys);
			temp_res <= tr;
			humid_res <= hr;
			humid_raw <= h;
			temp_raw <= t;
			cmd(k[0] ? `CMD_COMBO_NOHOLD : `CMD_TEMP_NOHOLD);
			chk(8'(conv_busy), 8'h1);
			rd(5, a);
			chk(8'(a), 8'h0);
			for (n = 0; a !== 1'b1 && n < 20; n++)
				rd(k[0] ? 5 : 3, a);
			build(scale(hr, h), scale(tr, t), k[0], 9'h0);
			cmpq();
			rd(k[0] ? 5 : 3, a);
			cmpq();
		end
		@(posedge clk_sys) ce <= 1'b0;
		repeat (6) @(posedge clk_sys);
		ce <= 1'b1;
		h = 14'(1 + $urandom % 16382);
		t = 14'(1 + $urandom % 16382);
		temp_res <= 2'h3;
		humid_res <= 2'h3;
		humid_raw <= h;
		temp_raw <= t;
		// Thresholds sit at the range ends so exactly temp over and humid under trigger.
		alert_thresh <= {14'h0, 14'h0, 14'h3fff, 14'h3fff};
		alert_hyst <= 14'($urandom);
		period_sel <= 2'($urandom);
		periodic_cfg_en <= 1'b1;
		wconv();
		chk(8'(periodic_active), 8'h1);
		cmd(`CMD_TEMP_NOHOLD);
		wconv();
		rd(5, a);
		build(h, t, 1'b1, 9'h0);
		cmpq();
		en = 4'($urandom) | 4'h1;
		pol = 1'($urandom);
		@(posedge clk_sys);
		alert_en <= en;
		alert_polarity <= pol;
		wconv();
		wconv();
		chk(8'(alert), 8'(!pol));
		rd(6, a);
		build(h, t, 1'b1, {5'h10, en & 4'h9});
		cmpq();
		@(posedge clk_sys);
		alert_en <= 4'h0;
		periodic_cfg_en <= 1'b0;
		cmd(`CMD_STOP_PERIODIC);
		repeat (4) @(posedge clk_sys);
		chk(8'(periodic_active), 8'h0);
		chk(8'(alert), 8'h1);
		cmd(`CMD_COMBO_NOHOLD);
		chk(8'(conv_busy), 8'h1);
		complete_run();
	end
endmodule : tb
